// File: core/mpe_encoder.sv
// Overview of operation
// - Each coded bit lasts 100 us, counted from the 200 MHz clock, giving 10 kbps.
// - An 8-bit CRC over the payload follows the last payload bit.
// - Payload and CRC bits both pass the coder before reaching the single output line.
// - A one bit toggles the line at the middle of its period.
// - A zero holds the line; a zero after a zero toggles at the boundary.
// - No bits are inserted; periods sent equal payload bits plus eight.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Byte buffer
// ----------------------------------------------------------------------------
module mpe_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic ready_q, ready_d;
	logic push, pop;

	assign push = in_valid & ready_q;
	assign out_valid = (cnt_q != CW'(0));
	assign pop = out_valid & out_ready;
	assign out_data = mem_q[rd_q];
	assign in_ready = ready_q;

	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_comb begin
			mem_d[i] = (push && wr_q == AW'(i)) ? in_data : mem_q[i];
		end
		always_ff @(posedge ref_clk or negedge arst_n) begin
			if (!arst_n) begin
				mem_q[i] <= '0;
			end else begin
				mem_q[i] <= mem_d[i];
			end
		end
	end

	always_comb begin
		wr_d = !push ? wr_q : (wr_q == AW'(DEPTH - 1)) ? '0 : AW'(wr_q + 1'b1);
		rd_d = !pop ? rd_q : (rd_q == AW'(DEPTH - 1)) ? '0 : AW'(rd_q + 1'b1);
		cnt_d = CW'(cnt_q + CW'(push) - CW'(pop));
		// Registered so that the source sees a ready that comes straight off a flop.
		ready_d = (cnt_d != CW'(DEPTH));
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			ready_q <= 1'b0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			ready_q <= ready_d;
		end
	end
endmodule // mpe_fifo

// ----------------------------------------------------------------------------
// Packet coder
// ----------------------------------------------------------------------------
module mpe_encoder import mpe_pkg::*; #(
	parameter int HALF_CYCLES = HALF_BIT_CYCLES,
	parameter logic [BYTE_W-1:0] CRC_POLY = CRC_POLY_DEFAULT,
	parameter logic [BYTE_W-1:0] CRC_INIT = CRC_INIT_DEFAULT,
	parameter bit CRC_MSB_FIRST = CRC_MSB_FIRST_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire mpe_byte_type in_byte,
	input wire logic in_valid,
	output logic in_ready,
	output logic line_out,
	output logic busy
);
	localparam logic [HALF_CNT_W-1:0] HALF_LAST = HALF_CNT_W'(HALF_CYCLES - 1);

	mpe_byte_type fifo_out;
	logic fifo_valid, pop, push_last, pop_last, nb_ok, nb;
	mpe_state_type state_q, state_d;
	logic [HALF_CNT_W-1:0] half_q, half_d;
	logic [BIT_IDX_W-1:0] bit_q, bit_d;
	logic [BYTE_W-1:0] sh_q, sh_d, crc_q, crc_d;
	logic [PKT_CNT_W-1:0] pkt_q, pkt_d;
	logic mid_q, mid_d, cur_q, cur_d, last_q, last_d, line_q, line_d, busy_q, busy_d;

	function automatic logic head(input logic [BYTE_W-1:0] v);
		head = CRC_MSB_FIRST ? v[BYTE_W-1] : v[0];
	endfunction

	function automatic logic [BYTE_W-1:0] adv(input logic [BYTE_W-1:0] v);
		adv = CRC_MSB_FIRST ? {v[BYTE_W-2:0], 1'b0} : {1'b0, v[BYTE_W-1:1]};
	endfunction

	function automatic logic [BYTE_W-1:0] crc_step(input logic [BYTE_W-1:0] c, input logic b);
		logic [BYTE_W-1:0] p;
		p = CRC_POLY;
		if (!CRC_MSB_FIRST) begin
			for (int i = 0; i < BYTE_W; i++) begin
				p[i] = CRC_POLY[BYTE_W-1-i];
			end
		end
		crc_step = adv(c) ^ ((head(c) ^ b) ? p : '0);
	endfunction

	mpe_fifo #(
		.WIDTH($bits(mpe_byte_type)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.in_data(in_byte),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.out_data(fifo_out),
		.out_valid(fifo_valid),
		.out_ready(pop)
	);

	// A packet starts only once its last byte is buffered, so the line never starves.
	assign push_last = in_valid & in_ready & in_byte.last;
	assign pop_last = pop & fifo_out.last;

	always_comb begin
		state_d = state_q;
		half_d = half_q;
		bit_d = bit_q;
		sh_d = sh_q;
		crc_d = crc_q;
		mid_d = mid_q;
		cur_d = cur_q;
		last_d = last_q;
		line_d = line_q;
		pop = 1'b0;
		nb_ok = 1'b0;
		nb = 1'b0;
		pkt_d = PKT_CNT_W'(pkt_q + PKT_CNT_W'(push_last) - PKT_CNT_W'(pop_last));
		case (state_q)
			MPE_IDLE: begin
				half_d = '0;
				mid_d = 1'b0;
				if (pkt_q != '0 && fifo_valid) begin
					pop = 1'b1;
					sh_d = fifo_out.data;
					last_d = fifo_out.last;
					bit_d = '0;
					state_d = MPE_DATA;
					cur_d = head(fifo_out.data);
					crc_d = crc_step(CRC_INIT, head(fifo_out.data));
				end
			end
			MPE_DATA, MPE_CRC: begin
				if (half_q == HALF_LAST) begin
					half_d = '0;
					if (!mid_q) begin
						mid_d = 1'b1;
						line_d = line_q ^ cur_q;
					end else begin
						mid_d = 1'b0;
						bit_d = BIT_IDX_W'(bit_q + 1'b1);
						if (bit_q != BIT_IDX_LAST) begin
							nb_ok = 1'b1;
							if (state_q == MPE_DATA) begin
								sh_d = adv(sh_q);
								nb = head(adv(sh_q));
								crc_d = crc_step(crc_q, nb);
							end else begin
								crc_d = adv(crc_q);
								nb = head(adv(crc_q));
							end
						end else if (state_q == MPE_DATA && !last_q) begin
							pop = 1'b1;
							nb_ok = 1'b1;
							sh_d = fifo_out.data;
							last_d = fifo_out.last;
							nb = head(fifo_out.data);
							crc_d = crc_step(crc_q, nb);
						end else if (state_q == MPE_DATA) begin
							state_d = MPE_CRC;
							nb_ok = 1'b1;
							nb = head(crc_q);
						end else begin
							state_d = MPE_IDLE;
						end
						if (nb_ok) begin
							cur_d = nb;
						end
						line_d = line_q ^ (nb_ok && !cur_q && !nb);
					end
				end else begin
					half_d = HALF_CNT_W'(half_q + 1'b1);
				end
			end
			default: state_d = MPE_IDLE;
		endcase
		busy_d = (state_d != MPE_IDLE);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= MPE_IDLE;
			half_q <= '0;
			bit_q <= '0;
			sh_q <= '0;
			crc_q <= '0;
			pkt_q <= '0;
			mid_q <= 1'b0;
			cur_q <= 1'b0;
			last_q <= 1'b0;
			line_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			half_q <= half_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			crc_q <= crc_d;
			pkt_q <= pkt_d;
			mid_q <= mid_d;
			cur_q <= cur_d;
			last_q <= last_d;
			line_q <= line_d;
			busy_q <= busy_d;
		end
	end

	assign line_out = line_q;
	assign busy = busy_q;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	chk_line_timing: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(line_q != $past(line_q)) |-> ($past(half_q) == HALF_LAST && $past(state_q) != MPE_IDLE)
	) else $error("line moved off a half-period edge");
	chk_one_mid: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(state_q != MPE_IDLE && half_q == HALF_LAST && !mid_q && cur_q) |=> (line_q != $past(line_q))
	) else $error("one bit missed its middle toggle");
	chk_zero_hold: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(state_q != MPE_IDLE && half_q == HALF_LAST && !mid_q && !cur_q) |=> $stable(line_q)
	) else $error("zero bit toggled mid period");
	chk_zero_pair: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(state_q != MPE_IDLE && half_q == HALF_LAST && mid_q && nb_ok && !cur_q && !nb)
		|=> (line_q != $past(line_q)) ##1 $stable(line_q)
	) else $error("zero pair missed boundary toggle");
	chk_crc_follows: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(state_q == MPE_DATA && half_q == HALF_LAST && mid_q && bit_q == BIT_IDX_LAST && last_q)
		|=> (state_q == MPE_CRC && bit_q == '0 && cur_q == head($past(crc_q)))
	) else $error("crc field did not follow payload");
	chk_crc_length: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(state_q == MPE_CRC && half_q == HALF_LAST && mid_q && bit_q == BIT_IDX_LAST)
		|=> (state_q == MPE_IDLE && !busy)
	) else $error("crc field length wrong");
	chk_crc_seed: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(state_q == MPE_IDLE && pop)
		|=> (crc_q == crc_step(CRC_INIT, cur_q) && cur_q == head($past(fifo_out.data)))
	) else $error("crc seed or first bit wrong");
	chk_idle_quiet: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(state_q == MPE_IDLE && !pop) |=> $stable(line_q)
	) else $error("line moved while idle");
endmodule // mpe_encoder

`default_nettype wire

// File: core/mpe_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants and types
// ----------------------------------------------------------------------------
package mpe_pkg;
	localparam int CLK_MHZ = 200;
	localparam int BIT_RATE_KBPS = 10;
	localparam int BIT_PERIOD_US = 100;
	// Half of a bit period, in clock cycles; the coder acts on half periods.
	localparam int HALF_BIT_CYCLES = BIT_PERIOD_US * CLK_MHZ / 2;
	localparam int HALF_CNT_W = 16;
	localparam int BYTE_W = 8;
	localparam int BIT_IDX_W = 3;
	localparam logic [BIT_IDX_W-1:0] BIT_IDX_LAST = 3'h7;
	localparam int FIFO_DEPTH = 16;
	localparam int PKT_CNT_W = 5;
	localparam logic [BYTE_W-1:0] CRC_POLY_DEFAULT = 8'h07;
	localparam logic [BYTE_W-1:0] CRC_INIT_DEFAULT = 8'h00;
	localparam bit CRC_MSB_FIRST_DEFAULT = 1'b1;

	typedef struct packed {
		logic last;
		logic [BYTE_W-1:0] data;
	} mpe_byte_type;

	typedef enum logic [1:0] {
		MPE_IDLE = 2'h0,
		MPE_DATA = 2'h1,
		MPE_CRC = 2'h3
	} mpe_state_type;
endpackage

// File: tb/mpe_rf_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Modulator input model: decodes the coded line back into bits
// ----------------------------------------------------------------------------
module mpe_rf_model #(
	parameter int HALF = 4
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic line_out,
	input wire logic busy,
	output logic bit_valid,
	output logic bit_val,
	output logic code_err,
	output int bit_total
);
	int j;
	logic a, cur, prev_b, prev_zero, last;

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			j = 0;
			prev_b = 1'b0;
			prev_zero = 1'b0;
			last = 1'b0;
			bit_valid <= 1'b0;
			bit_val <= 1'b0;
			code_err <= 1'b0;
			bit_total <= 0;
		end else begin
			bit_valid <= 1'b0;
			code_err <= 1'b0;
			if (busy !== 1'b1) begin
				j = 0;
				prev_b = line_out;
				prev_zero = 1'b0;
			end else begin
				// Line moves only on half-period edges.
				if ((j % HALF) != 0 && line_out !== last)
					code_err <= 1'b1;
				if ((j % (2 * HALF)) == HALF / 2)
					a = line_out;
				if ((j % (2 * HALF)) == HALF + HALF / 2) begin
					// Midpoint toggle means one; boundary toggle only between zeros.
					cur = (a !== line_out);
					if ((a !== prev_b) !== (prev_zero && !cur))
						code_err <= 1'b1;
					bit_val <= cur;
					bit_valid <= 1'b1;
					bit_total <= bit_total + 1;
					prev_zero = !cur;
					prev_b = line_out;
				end
				j = j + 1;
			end
			last = line_out;
		end
	end
endmodule // mpe_rf_model

`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t %s", $time, msg); end end

module tb_top;
	import mpe_pkg::*;
	localparam int HALF = 4;
	localparam int LIMIT = 20000;
	logic ref_clk, arst_n, in_valid, in_ready, line_out, busy, m_valid, m_bit, m_err;
	mpe_byte_type in_byte;
	int m_total, exp_total, error_cnt, num_checks, n;
	logic exp_q[$];

	mpe_encoder #(.HALF_CYCLES(HALF)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
		.in_byte(in_byte), .in_valid(in_valid), .in_ready(in_ready),
		.line_out(line_out), .busy(busy));
	mpe_rf_model #(.HALF(HALF)) u_rf (.ref_clk(ref_clk), .arst_n(arst_n),
		.line_out(line_out), .busy(busy), .bit_valid(m_valid), .bit_val(m_bit),
		.code_err(m_err), .bit_total(m_total));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// A refused byte stays offered until the buffer has room again.
	task automatic send_byte(input logic lst, input logic [7:0] d);
		int k;
		k = 0;
		@(negedge ref_clk);
		in_byte = '{last: lst, data: d};
		in_valid = 1'b1;
		while (in_ready !== 1'b1 && k < LIMIT) begin
			@(negedge ref_clk);
			k++;
		end
		if (k >= LIMIT) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t input stalled", $time);
			tally_and_finish();
		end
	endtask

	task automatic send_pkt(input int len, input logic [7:0] fixd, input bit rnd);
		logic [7:0] d, crc;
		logic fb;
		crc = CRC_INIT_DEFAULT;
		for (int i = 0; i < len; i++) begin
			d = rnd ? 8'($urandom) : fixd;
			// Reference CRC from the default parameters, MSB first.
			for (int k = 7; k >= 0; k--) begin
				exp_q.push_back(d[k]);
				fb = crc[7] ^ d[k];
				crc = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY_DEFAULT : 8'h00);
			end
			send_byte(i == len - 1, d);
		end
		for (int k = 7; k >= 0; k--)
			exp_q.push_back(crc[k]);
		exp_total += 8 * len + 8;
	endtask

	// ------------------------------------------------------------------------
	// Result checker
	// ------------------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (m_valid === 1'b1) begin
			if (exp_q.size() == 0)
				`CHK(1'b1, 1'b0, "unexpected extra bit")
			else
				`CHK(m_bit, exp_q.pop_front(), "decoded bit mismatch")
		end
		if (m_err === 1'b1)
			`CHK(m_err, 1'b0, "line coding or timing error")
	end

	initial begin
		in_valid = 1'b0;
		in_byte = '0;
		arst_n = 1'b0;
		error_cnt = 0;
		num_checks = 0;
		exp_total = 0;
		void'($urandom(32'h4E13));
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		arst_n = 1'b1;
		@(negedge ref_clk);
		`CHK(line_out, 1'b0, "line idle after reset")
		`CHK(busy, 1'b0, "busy after reset")
		`CHK(in_ready, 1'b1, "ready after reset")
		send_pkt(1, 8'h00, 1'b0);
		send_pkt(1, 8'hFF, 1'b0);
		send_pkt(2, 8'h55, 1'b0);
		// Three earlier bytes are still queued, so the buffer fills during these sixteen bytes and the packet itself must wait for room.
		send_pkt(16, 8'h00, 1'b1);
		send_pkt(3, 8'h00, 1'b1);
		repeat (5) send_pkt(1 + ($urandom % 16), 8'h00, 1'b1);
		@(negedge ref_clk);
		in_valid = 1'b0;
		n = 0;
		while ((exp_q.size() != 0 || busy !== 1'b0) && n < LIMIT) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= LIMIT) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t output never drained", $time);
		end
		`CHK(m_total, exp_total, "bit period count")
		tally_and_finish();
	end
endmodule // tb_top

`default_nettype wire
